// *** design/dspcb_pkg.sv ***
package dspcb_pkg;
  localparam int unsigned IFACE_ADDR_LO   = 1048;
  localparam int unsigned IFACE_ADDR_HI   = 2055;
  localparam int unsigned IFACE_COUNT     = IFACE_ADDR_HI - IFACE_ADDR_LO + 1;
  localparam int unsigned SL_ENTRIES      = 5;
  localparam int unsigned CP_ADDR_W       = 12;
  localparam int unsigned PRAM_ADDR_W     = 10;
  localparam int unsigned WORD_W          = 28;
  localparam logic [1:0]  RATE_1X         = 2'h0;
  localparam logic [1:0]  RATE_2X         = 2'h1;
  localparam logic [1:0]  RATE_4X         = 2'h2;
  localparam int unsigned INSTR_1X        = 1024;
  localparam int unsigned INSTR_2X        = 512;
  localparam int unsigned INSTR_4X        = 256;
  localparam int unsigned INSTR_W         = 10;
  localparam logic        CTL_BIT_RST     = 1'b0;
  localparam logic [1:0]  RATE_RST        = RATE_1X;
  localparam logic [2:0]  MULT_1X         = 3'h1;
  localparam logic [2:0]  MULT_2X         = 3'h2;
  localparam logic [2:0]  MULT_4X         = 3'h4;
  typedef enum logic [1:0] {SL_IDLE, SL_READ, SL_WRITE} dspcb_sl_state_t;
endpackage

// *** design/dspcb_sl_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
module dspcb_sl_mem import dspcb_pkg::*; #(
  parameter int unsigned DEPTH = SL_ENTRIES,
  parameter int unsigned AW    = PRAM_ADDR_W,
  parameter int unsigned DW    = WORD_W
) (
  input  wire logic          ref_clk,  // Core clock
  input  wire logic          clk_en,   // Freezes state when low
  input  wire logic          wr_en,    // Entry write strobe
  input  wire logic [2:0]    wr_idx,   // Entry written
  input  wire logic [AW-1:0] wr_addr,  // Parameter address
  input  wire logic [DW-1:0] wr_data,  // Parameter data
  input  wire logic [2:0]    rd_idx,   // Entry read
  output var  logic [AW-1:0] rd_addr,  // Registered address
  output var  logic [DW-1:0] rd_data   // Registered data
);
  logic [AW-1:0] addr_q [DEPTH];
  logic [DW-1:0] data_q [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en && (32'(wr_idx) < DEPTH)) begin
      addr_q[wr_idx] <= wr_addr;
      data_q[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && (32'(rd_idx) < DEPTH)) begin
      rd_addr <= addr_q[rd_idx];
      rd_data <= data_q[rd_idx];
    end
  end
endmodule // dspcb_sl_mem
`default_nettype wire

// *** design/dspcb_instr_cnt.sv ***
`timescale 1ns/1ns
`default_nettype none
module dspcb_instr_cnt import dspcb_pkg::*; (
  input  wire logic               ref_clk,      // Core clock
  input  wire logic               sys_rst,      // Sync reset, high
  input  wire logic               clk_en,       // Freezes state when low
  input  wire logic [1:0]         rate_select,  // Registered rate field
  output var  logic [INSTR_W-1:0] instr_idx,    // Instruction slot
  output var  logic               sample_tick   // Start of sample frame
);
  localparam logic [INSTR_W-1:0] LAST_1X = INSTR_W'(INSTR_1X - 1);
  localparam logic [INSTR_W-1:0] LAST_2X = INSTR_W'(INSTR_2X - 1);
  localparam logic [INSTR_W-1:0] LAST_4X = INSTR_W'(INSTR_4X - 1);

  wire logic [INSTR_W-1:0] last_slot = (rate_select == RATE_2X) ? LAST_2X :
                                       (rate_select == RATE_4X) ? LAST_4X :
                                       LAST_1X;
  wire logic               wrap      = (instr_idx >= last_slot);
  wire logic [INSTR_W-1:0] next_idx  = wrap ? '0 : instr_idx + INSTR_W'(1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      instr_idx   <= '0;
      sample_tick <= 1'b0;
    end else if (clk_en) begin
      instr_idx   <= next_idx;
      sample_tick <= wrap;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_wrap_1x_slot: assert property (
    clk_en && rate_select == RATE_1X && instr_idx == LAST_1X ##1 clk_en |-> instr_idx == '0 && sample_tick)
    else $error("1x frame did not wrap after 1024 slots");
  chk_wrap_2x_slot: assert property (
    clk_en && rate_select == RATE_2X && instr_idx == LAST_2X ##1 clk_en |-> instr_idx == '0 && sample_tick)
    else $error("2x frame did not wrap after 512 slots");
  chk_wrap_4x_slot: assert property (
    clk_en && rate_select == RATE_4X && instr_idx == LAST_4X ##1 clk_en |-> instr_idx == '0 && sample_tick)
    else $error("4x frame did not wrap after 256 slots");
endmodule // dspcb_instr_cnt
`default_nettype wire

// *** design/dspcb_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
module dspcb_ctrl import dspcb_pkg::*; #(
  parameter int unsigned AW = PRAM_ADDR_W,
  parameter int unsigned DW = WORD_W
) (
  input  wire logic                 ref_clk,                  // 250 MHz core clock
  input  wire logic                 sys_rst,                  // Sync reset, high
  input  wire logic                 clk_en,                   // Freezes all state when low
  input  wire logic                 ctl_wr,                   // Loads the control bits below
  input  wire logic                 ctl_iface_sel,            // New interface write select
  input  wire logic                 ctl_in_mute_n,            // New converter input mute
  input  wire logic                 ctl_out_mute_n,           // New converter output mute
  input  wire logic                 ctl_core_clear_n,         // New core clear
  input  wire logic [1:0]           ctl_rate_select,          // New rate field
  input  wire logic                 ctl_trigger_wr,           // Writes the trigger bit
  input  wire logic                 ctl_trigger_val,          // Value written to trigger
  input  wire logic                 sl_wr,                    // Safeload entry write
  input  wire logic [2:0]           sl_idx,                   // Entry index 0..4
  input  wire logic [AW-1:0]        sl_addr,                  // Entry parameter address
  input  wire logic [DW-1:0]        sl_data,                  // Entry parameter data
  input  wire logic                 cp_if_wr,                 // Control port iface write
  input  wire logic [CP_ADDR_W-1:0] cp_if_addr,               // Control port address
  input  wire logic [DW-1:0]        cp_if_data,               // Control port data
  input  wire logic                 prog_if_wr,               // Program iface write
  input  wire logic [2:0]           prog_if_idx,              // Program iface index
  input  wire logic [DW-1:0]        prog_if_data,             // Program iface data
  input  wire logic [2:0]           if_rd_idx,                // Iface read index
  input  wire logic [DW-1:0]        adc_in,                   // Converter input result
  input  wire logic [DW-1:0]        dac_in,                   // Core result to converters
  output var  logic                 iface_reg_port_write_sel, // Interface write select
  output var  logic                 safeload_trigger,         // Safeload busy/trigger bit
  output var  logic                 conv_in_mute_n,           // Input mute, low mutes
  output var  logic                 conv_out_mute_n,          // Output mute, low mutes
  output var  logic                 core_clear_n,             // Core clear, low clears
  output var  logic [1:0]           rate_select,              // Rate field
  output var  logic [2:0]           conv_rate_mult,           // Converter rate multiple
  output var  logic                 core_regs_clr,            // Holds core registers at 0
  output var  logic [DW-1:0]        adc_out,                  // Gated input result
  output var  logic [DW-1:0]        dac_out,                  // Gated output sample
  output var  logic [DW-1:0]        if_rd_data,               // Iface read data
  output var  logic                 pram_wr,                  // Parameter RAM write
  output var  logic [AW-1:0]        pram_addr,                // Parameter RAM address
  output var  logic [DW-1:0]        pram_data,                // Parameter RAM data
  output var  logic [INSTR_W-1:0]   instr_idx,                // Instruction slot
  output var  logic                 sample_tick               // Start of sample frame
);
  localparam logic [CP_ADDR_W-1:0] IF_LO = CP_ADDR_W'(IFACE_ADDR_LO);
  localparam logic [CP_ADDR_W-1:0] IF_HI = CP_ADDR_W'(IFACE_ADDR_HI);
  localparam logic [2:0]           SL_LAST = 3'(SL_ENTRIES - 1);
  localparam int unsigned          IF_SLOTS = 8;  // Reachable through a 3-bit index

  logic [DW-1:0]         iface_q [IF_SLOTS];
  logic [SL_ENTRIES-1:0] pending;
  logic [2:0]            scan_idx;
  dspcb_sl_state_t       sl_state;
  logic [AW-1:0]         mem_addr;
  logic [DW-1:0]         mem_data;

  // Interface register write selection
  wire logic                 cp_in_range  = (cp_if_addr >= IF_LO) && (cp_if_addr <= IF_HI);
  wire logic [CP_ADDR_W-1:0] cp_offset    = cp_if_addr - IF_LO;
  wire logic [2:0]           cp_idx       = cp_offset[2:0];
  wire logic                 cp_if_take   = cp_if_wr && cp_in_range && iface_reg_port_write_sel;
  wire logic                 prog_if_take = prog_if_wr && !iface_reg_port_write_sel;

  // Safeload sequencing
  wire logic                 sl_idx_ok    = 32'(sl_idx) < SL_ENTRIES;
  wire logic                 trig_start   = ctl_trigger_wr && ctl_trigger_val && (sl_state == SL_IDLE);
  wire logic                 scan_last    = (scan_idx == SL_LAST);
  wire logic                 scan_hit     = pending[scan_idx];
  wire logic                 sl_done      = ((sl_state == SL_READ) && !scan_hit && scan_last) ||
                                            ((sl_state == SL_WRITE) && scan_last);
  wire logic [2:0]           next_scan    = scan_last ? 3'h0 : scan_idx + 3'h1;
  wire logic                 in_write     = (sl_state == SL_WRITE);
  wire logic                 scan_step    = ((sl_state == SL_READ) && !scan_hit) || in_write;

  dspcb_sl_state_t next_state;
  always_comb begin
    next_state = sl_state;
    unique case (sl_state)
      SL_IDLE: begin
        if (trig_start) next_state = SL_READ;
      end
      SL_READ: begin
        if (scan_hit) next_state = SL_WRITE;
        else if (scan_last) next_state = SL_IDLE;
      end
      SL_WRITE: begin
        next_state = scan_last ? SL_IDLE : SL_READ;
      end
    endcase
  end

  // Entries written mark pending; the write wins over the transfer clearing it
  wire logic [SL_ENTRIES-1:0] set_mask   = (sl_wr && sl_idx_ok) ? SL_ENTRIES'(1) << sl_idx : '0;
  wire logic [SL_ENTRIES-1:0] clr_mask   = (sl_state == SL_WRITE) ? SL_ENTRIES'(1) << scan_idx : '0;
  wire logic [SL_ENTRIES-1:0] next_pend  = (pending & ~clr_mask) | set_mask;

  wire logic [2:0] next_mult = (ctl_rate_select == RATE_2X) ? MULT_2X :
                               (ctl_rate_select == RATE_4X) ? MULT_4X :
                               MULT_1X;

  dspcb_sl_mem #(.DEPTH(SL_ENTRIES), .AW(AW), .DW(DW)) u_sl_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .wr_en   (sl_wr),
    .wr_idx  (sl_idx),
    .wr_addr (sl_addr),
    .wr_data (sl_data),
    .rd_idx  (scan_idx),
    .rd_addr (mem_addr),
    .rd_data (mem_data)
  );

  dspcb_instr_cnt u_instr_cnt (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .rate_select (rate_select),
    .instr_idx   (instr_idx),
    .sample_tick (sample_tick)
  );

  // Control bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      iface_reg_port_write_sel <= CTL_BIT_RST;
      conv_in_mute_n           <= CTL_BIT_RST;
      conv_out_mute_n          <= CTL_BIT_RST;
      core_clear_n             <= CTL_BIT_RST;
      rate_select              <= RATE_RST;
      conv_rate_mult           <= MULT_1X;
    end else if (clk_en && ctl_wr) begin
      iface_reg_port_write_sel <= ctl_iface_sel;
      conv_in_mute_n           <= ctl_in_mute_n;
      conv_out_mute_n          <= ctl_out_mute_n;
      core_clear_n             <= ctl_core_clear_n;
      rate_select              <= ctl_rate_select;
      conv_rate_mult           <= next_mult;
    end
  end

  // Audio gating follows the registered mute and clear bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      adc_out       <= '0;
      dac_out       <= '0;
      core_regs_clr <= 1'b1;
    end else if (clk_en) begin
      adc_out       <= conv_in_mute_n ? adc_in : '0;
      dac_out       <= (conv_out_mute_n && core_clear_n) ? dac_in : '0;
      core_regs_clr <= !core_clear_n;
    end
  end

  // Interface registers; cleared only by reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < IF_SLOTS; i++) iface_q[i] <= '0;
      if_rd_data <= '0;
    end else if (clk_en) begin
      if (cp_if_take) begin
        iface_q[cp_idx] <= cp_if_data;
      end else if (prog_if_take) begin
        iface_q[prog_if_idx] <= prog_if_data;
      end
      if_rd_data <= iface_q[if_rd_idx];
    end
  end

  // Safeload state and pending marks
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sl_state <= SL_IDLE;
      pending  <= '0;
    end else if (clk_en) begin
      sl_state <= next_state;
      pending  <= next_pend;
    end
  end

  // Parameter RAM port; address and data hold between pulses
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pram_wr   <= 1'b0;
      pram_addr <= '0;
      pram_data <= '0;
    end else if (clk_en) begin
      pram_wr <= in_write;
      if (in_write) begin
        pram_addr <= mem_addr;
        pram_data <= mem_data;
      end
    end
  end

  // Trigger bit and entry scan
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      safeload_trigger <= 1'b0;
      scan_idx         <= 3'h0;
    end else if (clk_en) begin
      if (trig_start) begin
        safeload_trigger <= 1'b1;
      end else if (sl_done) begin
        safeload_trigger <= 1'b0;
      end
      if (trig_start) begin
        scan_idx <= 3'h0;
      end else if (scan_step) begin
        scan_idx <= next_scan;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_sl_start;
    clk_en && trig_start;
  endsequence
  sequence s_sl_busy;
    safeload_trigger && sl_state != SL_IDLE;
  endsequence
  sequence s_entry_hit;
    clk_en && sl_state == SL_READ && scan_hit;
  endsequence

  chk_cp_iface_write: assert property (
    clk_en && cp_if_take |=> iface_q[$past(cp_idx)] == $past(cp_if_data))
    else $error("Control port iface write not stored");
  chk_prog_write_block: assert property (
    clk_en && iface_reg_port_write_sel && !cp_if_wr && !ctl_wr |=>
      iface_q[$past(prog_if_idx)] == $past(iface_q[prog_if_idx]))
    else $error("Program write reached iface registers while blocked");
  chk_trigger_starts: assert property (
    s_sl_start |=> s_sl_busy)
    else $error("Trigger write did not start safeload");
  chk_trigger_self_clear: assert property (
    s_sl_start |-> ##[1:20] !safeload_trigger)
    else $error("Trigger bit not cleared after transfer");
  chk_trigger_hold_busy: assert property (
    clk_en && $fell(safeload_trigger) |-> sl_state == SL_IDLE && $past(sl_done))
    else $error("Trigger bit fell before transfer ended");
  chk_five_entries: assert property (
    clk_en && sl_wr && sl_idx_ok |=> pending[$past(sl_idx)])
    else $error("Safeload entry write not marked pending");
  chk_skip_unwritten: assert property (
    clk_en && sl_state == SL_READ && !pending[scan_idx] |=> !pram_wr)
    else $error("Unwritten safeload entry was transferred");
  chk_in_mute_gate: assert property (
    clk_en && !conv_in_mute_n |=> adc_out == '0)
    else $error("Converter input not muted");
  chk_out_mute_gate: assert property (
    clk_en && !conv_out_mute_n |=> dac_out == '0)
    else $error("Converter output not muted");
  chk_core_clear_hold: assert property (
    clk_en && !core_clear_n |=> core_regs_clr && dac_out == '0)
    else $error("Core not held clear");
  chk_entry_to_pram: assert property (
    s_entry_hit ##1 clk_en |=> pram_wr && pram_addr == $past(u_sl_mem.addr_q[scan_idx], 2) &&
      pram_data == $past(u_sl_mem.data_q[scan_idx], 2))
    else $error("Safeload entry not copied to parameter RAM");
  chk_pram_one_shot: assert property (
    clk_en && pram_wr |=> !pram_wr)
    else $error("Parameter RAM write held past one cycle");
  chk_write_needs_pending: assert property (
    clk_en && sl_state == SL_WRITE |-> pending[scan_idx])
    else $error("Transfer of an entry that is not pending");
  chk_trigger_min_busy: assert property (
    s_sl_start |=> safeload_trigger [*5])
    else $error("Trigger bit cleared before all entries were scanned");
  chk_cp_range_refuse: assert property (
    clk_en && cp_if_wr && !cp_in_range && !prog_if_wr |=> iface_q[$past(cp_idx)] == $past(iface_q[cp_idx]))
    else $error("Out-of-range control port write changed iface registers");
  chk_rate_2x_mult: assert property (
    rate_select == RATE_2X |-> conv_rate_mult == MULT_2X)
    else $error("2x rate without doubled converter rate");
  chk_rate_4x_mult: assert property (
    rate_select == RATE_4X |-> conv_rate_mult == MULT_4X)
    else $error("4x rate without quadrupled converter rate");
  chk_core_clear_release: assert property (
    clk_en && core_clear_n |=> !core_regs_clr)
    else $error("Core held clear after release");
  chk_in_mute_pass: assert property (
    clk_en && conv_in_mute_n |=> adc_out == $past(adc_in))
    else $error("Converter input blocked while unmuted");
  chk_out_mute_pass: assert property (
    clk_en && conv_out_mute_n && core_clear_n |=> dac_out == $past(dac_in))
    else $error("Converter output blocked while unmuted");
endmodule // dspcb_ctrl
`default_nettype wire

// *** verif/dspcb_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dspcb_host_model import dspcb_pkg::*; (
  input  wire logic                   ref_clk,          // Core clock
  output var  logic                   ctl_wr,           // Control bit load
  output var  logic                   ctl_iface_sel,    // Interface write select
  output var  logic                   ctl_in_mute_n,    // Input mute
  output var  logic                   ctl_out_mute_n,   // Output mute
  output var  logic                   ctl_core_clear_n, // Core clear
  output var  logic [1:0]             ctl_rate_select,  // Rate field
  output var  logic                   ctl_trigger_wr,   // Trigger write
  output var  logic                   ctl_trigger_val,  // Trigger value
  output var  logic                   sl_wr,            // Entry write
  output var  logic [2:0]             sl_idx,           // Entry index
  output var  logic [PRAM_ADDR_W-1:0] sl_addr,          // Entry address
  output var  logic [WORD_W-1:0]      sl_data           // Entry data
);
  initial begin
    {ctl_wr, ctl_iface_sel, ctl_in_mute_n, ctl_out_mute_n, ctl_core_clear_n} = 5'h00;
    {ctl_rate_select, ctl_trigger_wr, ctl_trigger_val, sl_wr, sl_idx} = 8'h00;
    sl_addr = '0;
    sl_data = '0;
  end

  // Qualifiers other than the rate field are inverted once the strobe drops so stale values never look valid
  task automatic set_ctl(input logic sel, imn, omn, ccn, input logic [1:0] rs);
    @(posedge ref_clk);
    ctl_wr <= 1'h1;
    {ctl_iface_sel, ctl_in_mute_n, ctl_out_mute_n, ctl_core_clear_n} <= {sel, imn, omn, ccn};
    ctl_rate_select <= (rs == 2'h3) ? RATE_RST : rs;
    @(posedge ref_clk);
    ctl_wr <= 1'h0;
    {ctl_iface_sel, ctl_in_mute_n, ctl_out_mute_n, ctl_core_clear_n} <= ~{sel, imn, omn, ccn};
  endtask

  task automatic write_entry(input logic [2:0] i, input logic [PRAM_ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge ref_clk);
    {sl_wr, sl_idx, sl_addr, sl_data} <= {1'h1, i, a, d};
    @(posedge ref_clk);
    {sl_wr, sl_idx, sl_addr, sl_data} <= {1'h0, ~i, ~a, ~d};
  endtask

  task automatic pull_trigger(input int unsigned gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    {ctl_trigger_wr, ctl_trigger_val} <= 2'h3;
    @(posedge ref_clk);
    {ctl_trigger_wr, ctl_trigger_val} <= 2'h0;
  endtask
endmodule // dspcb_host_model
`default_nettype wire

// *** verif/dspcb_ctrl_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module dspcb_ctrl_bench import dspcb_pkg::*; ;
  logic ref_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, cp_if_wr = 1'h0, prog_if_wr = 1'h0;
  logic ctl_wr, ctl_iface_sel, ctl_in_mute_n, ctl_out_mute_n, ctl_core_clear_n, ctl_trigger_wr, ctl_trigger_val, sl_wr;
  logic iface_reg_port_write_sel, safeload_trigger, conv_in_mute_n, conv_out_mute_n, core_clear_n, core_regs_clr;
  logic pram_wr, sample_tick;
  logic [1:0]             ctl_rate_select, rate_select;
  logic [2:0]             sl_idx, conv_rate_mult, prog_if_idx = 3'h0, if_rd_idx = 3'h0;
  logic [PRAM_ADDR_W-1:0] sl_addr, pram_addr, ea[$], got_a[$];
  logic [WORD_W-1:0]      sl_data, pram_data, adc_out, dac_out, if_rd_data, ir[8], ed[$], got_d[$];
  logic [WORD_W-1:0]      cp_if_data = '0, prog_if_data = '0, adc_in = '0, dac_in = '0;
  logic [CP_ADDR_W-1:0]   cp_if_addr = 12'h000;
  logic [INSTR_W-1:0]     instr_idx;
  logic [31:0]            seed = 32'h48;
  int                     n_fail = 0, tests_run = 0, cycles = 0, n, p;

  dspcb_ctrl u_dspcb_ctrl (.*);
  dspcb_host_model u_host (.*);

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (pram_wr === 1'h1) begin
      got_a.push_back(pram_addr);
      got_d.push_back(pram_data);
    end
    if (cycles == 20000) begin
      n_fail++;
      $display("unexpected at %0t: run limit reached", $time);
      wrap_up();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [2:0] exp_mult(input logic [1:0] r);
    return (r == RATE_2X) ? MULT_2X : (r == RATE_4X) ? MULT_4X : MULT_1X;
  endfunction

  function automatic int unsigned exp_frame(input logic [1:0] r);
    return (r == RATE_2X) ? INSTR_2X : (r == RATE_4X) ? INSTR_4X : INSTR_1X;
  endfunction

  task automatic check(input logic [31:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_tick(output int cnt);
    cnt = 0;
    do begin
      tick(1);
      cnt++;
    end while (sample_tick !== 1'h1 && cnt < 1100);
  endtask

  task automatic cp_wr(input logic [CP_ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge ref_clk);
    {cp_if_wr, cp_if_addr, cp_if_data} <= {1'h1, a, d};
    @(posedge ref_clk);
    {cp_if_wr, cp_if_addr, cp_if_data} <= {1'h0, ~a, ~d};
  endtask

  task automatic prog_wr(input logic [2:0] i, input logic [WORD_W-1:0] d);
    @(posedge ref_clk);
    {prog_if_wr, prog_if_idx, prog_if_data} <= {1'h1, i, d};
    @(posedge ref_clk);
    {prog_if_wr, prog_if_idx, prog_if_data} <= {1'h0, ~i, ~d};
  endtask

  task automatic rd_chk(input logic [2:0] i);
    @(posedge ref_clk);
    if_rd_idx <= i;
    tick(2);
    check(if_rd_data, ir[i], "interface register");
  endtask

  task automatic wrap_up();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    int unsigned a32;
    logic [2:0]  ix;
    logic [4:0]  mask;
    for (int i = 0; i < 8; i++) ir[i] = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'h0;
    tick(1);
    check(conv_in_mute_n, 1'h0, "input mute at reset");
    check(conv_out_mute_n, 1'h0, "output mute at reset");
    check({core_clear_n, core_regs_clr}, 2'h1, "core clear at reset");
    check({rate_select, iface_reg_port_write_sel, safeload_trigger}, 4'h0, "rate and flags at reset");
    // Every mute and clear combination against random audio
    for (int k = 0; k < 8; k++) begin
      u_host.set_ctl(1'h1, k[0], k[1], k[2], RATE_1X);
      seed = lfsr(seed);
      @(posedge ref_clk);
      adc_in <= seed[27:0];
      dac_in <= ~seed[31:4];
      tick(1);
      check(adc_out, k[0] ? adc_in : '0, "input gate");
      check(dac_out, (k[1] && k[2]) ? dac_in : '0, "output gate");
      check(core_regs_clr, !k[2], "core hold");
    end
    for (int r = 0; r < 3; r++) begin
      u_host.set_ctl(1'h1, 1'h1, 1'h1, 1'h1, r[1:0]);
      tick(1);
      check(conv_rate_mult, exp_mult(r[1:0]), "rate multiple");
      wait_tick(n);
      wait_tick(n);
      check(n, exp_frame(r[1:0]), "frame length");
      check(instr_idx, 10'h000, "slot at frame start");
    end
    // Clock enable low freezes the frame counter
    @(posedge ref_clk);
    clk_en <= 1'h0;
    tick(1);
    a32 = instr_idx;
    tick(7);
    check(instr_idx, a32, "frozen slot");
    @(posedge ref_clk);
    clk_en <= 1'h1;
    // All entries, none, then random subsets
    for (int it = 0; it < 6; it++) begin
      seed = lfsr(seed);
      mask = (it == 0) ? 5'h1F : (it == 1) ? 5'h00 : seed[4:0];
      ea.delete(); ed.delete(); got_a.delete(); got_d.delete();
      for (int i = 0; i < SL_ENTRIES; i++) begin
        if (mask[i]) begin
          seed = lfsr(seed);
          ea.push_back(seed[9:0]);
          ed.push_back(seed[31:4]);
          u_host.write_entry(i[2:0], ea[$], ed[$]);
        end
      end
      p = ea.size();
      u_host.pull_trigger(it % 3);
      #1;
      check(safeload_trigger, 1'h1, "trigger set");
      n = 0;
      while (safeload_trigger === 1'h1 && n < 12) begin
        tick(1);
        n++;
      end
      check(n, 5 + p, "transfer cycles");
      tick(3);
      check(got_a.size(), p, "parameter writes");
      for (int i = 0; i < p && i < got_a.size(); i++) begin
        check(got_a[i], ea[i], "parameter address");
        check(got_d[i], ed[i], "parameter data");
      end
    end
    // Bounds and out-of-range addresses under both select settings
    for (int s = 1; s >= 0; s--) begin
      u_host.set_ctl(s[0], 1'h1, 1'h1, 1'h1, RATE_1X);
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        a32 = (k == 0) ? IFACE_ADDR_LO : (k == 1) ? IFACE_ADDR_HI : (k == 2) ? IFACE_ADDR_LO - 1 :
              (k == 3) ? IFACE_ADDR_HI + 1 : IFACE_ADDR_LO + seed % IFACE_COUNT;
        ix = 3'(a32 - IFACE_ADDR_LO);
        cp_wr(a32[11:0], seed[27:0]);
        if (s == 1 && a32 >= IFACE_ADDR_LO && a32 <= IFACE_ADDR_HI) ir[ix] = seed[27:0];
        rd_chk(ix);
        prog_wr(seed[30:28], ~seed[27:0]);
        if (s == 0) ir[seed[30:28]] = ~seed[27:0];
        rd_chk(seed[30:28]);
      end
    end
    wrap_up();
  end
endmodule // dspcb_ctrl_bench
`default_nettype wire
